// ===== design/crp_pkg.sv
// shared constants and types for the cascaded rgb pixel receiver
package crp_pkg;
  localparam int CLK_NS = 10;
  localparam int BIT_NS = 1250;
  localparam int TX_HIGH0_NS = 400;
  localparam int TX_HIGH1_NS = 850;
  localparam int RX_HIGH_MIN_NS = 300;
  localparam int RX_THRESH_NS = 600;
  localparam int GAP_US = 250;
  localparam int SILENT_US = 150;
  localparam int REFRESH_HZ = 2000;
  localparam int LEVELS = 256;
  localparam int WORD_BITS = 24;

  localparam logic [6:0] BIT_CYC = 7'(BIT_NS / CLK_NS);
  localparam logic [6:0] TX_HIGH0_CYC = 7'(TX_HIGH0_NS / CLK_NS);
  localparam logic [6:0] TX_HIGH1_CYC = 7'(TX_HIGH1_NS / CLK_NS);
  localparam logic [6:0] RX_HIGH_MIN_CYC = 7'((RX_HIGH_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [6:0] RX_THRESH_CYC = 7'(RX_THRESH_NS / CLK_NS);
  localparam int GAP_CYC = GAP_US * 1000 / CLK_NS;
  localparam int SILENT_CYC = SILENT_US * 1000 / CLK_NS;
  localparam logic [7:0] STEP_CYC = 8'(1000000000 / (REFRESH_HZ * LEVELS * CLK_NS));
  localparam logic [4:0] LAST_BIT_IDX = 5'(WORD_BITS - 1);
  localparam logic [4:0] SKIP_BITS = 5'(WORD_BITS);

  // green first on the wire, msb first, so green sits on top
  typedef struct packed {
    logic [7:0] green;
    logic [7:0] red;
    logic [7:0] blue;
  } crp_colour_t;

  typedef struct packed {
    logic valid;
    logic value;
    logic gap;
    logic silent;
  } crp_rx_t;

  typedef enum logic [1:0] {
    CRP_CAPTURE = 2'b01,
    CRP_FORWARD = 2'b10
  } crp_cap_state_t;

  typedef enum logic [2:0] {
    CRP_TX_IDLE = 3'b001,
    CRP_TX_HIGH = 3'b010,
    CRP_TX_LOW = 3'b100
  } crp_tx_state_t;
endpackage

// ===== design/crp_pixel_rx.sv
// pulse-width bit decoder and the cascaded pixel receiver top
`timescale 1ns/1ps
`default_nettype none

module crp_bit_decoder import crp_pkg::*; #(
  parameter int GAP_CYCLES = GAP_CYC,
  parameter int SILENT_CYCLES = SILENT_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic line_in,
  output crp_rx_t rx_out
);
  localparam int LW = $clog2(GAP_CYCLES + 1);
  logic s1_ff, s2_ff, s3_ff;
  logic [6:0] high_cnt_ff;
  logic [LW-1:0] low_cnt_ff;
  crp_rx_t rx_ff;
  wire fall = s3_ff & ~s2_ff;
  wire high_sat = (high_cnt_ff == 7'h7f);
  wire low_sat = (low_cnt_ff == LW'(GAP_CYCLES));

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      {s1_ff, s2_ff, s3_ff} <= 3'h0;
      high_cnt_ff <= 7'h00;
      low_cnt_ff <= '0;
      rx_ff <= '0;
    end else begin
      s1_ff <= line_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      high_cnt_ff <= s2_ff ? (high_sat ? high_cnt_ff : high_cnt_ff + 7'h01) : 7'h00;
      low_cnt_ff <= s2_ff ? '0 : (low_sat ? low_cnt_ff : low_cnt_ff + LW'(1));
      // short glitches are not bits
      rx_ff.valid <= fall & (high_cnt_ff >= RX_HIGH_MIN_CYC); // RULE13
      rx_ff.value <= (high_cnt_ff >= RX_THRESH_CYC); // RULE13
      // one pulse per gap, pauses below the limit pass unnoticed
      rx_ff.gap <= ~s2_ff & (low_cnt_ff == LW'(GAP_CYCLES - 1)); // RULE7
      rx_ff.silent <= ~s2_ff & (low_cnt_ff >= LW'(SILENT_CYCLES - 1));
    end
  end
  assign rx_out = rx_ff;

  a_gap_low_time: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE7
    rx_ff.gap |-> $past(low_cnt_ff) == LW'(GAP_CYCLES - 1) && !$past(s2_ff))
    else $error("gap flagged before the low time elapsed");
endmodule

////////////////////////////////////////////////////////////////////////////////

// Contract
// RULE1: after reset keep first 24 bits
// RULE2: regenerate and send on later bits
// RULE3: output stream 24 bits shorter
// RULE4: backup drops 24 bits, compared with primary
// RULE5: primary silent means take backup input
// RULE6: backup stays until power cycle
// RULE7: low of 250 us ends frame
// RULE8: three 8-bit channels, 256 levels
// RULE9: channel outputs refresh at 2 kHz
// RULE10: link runs at most 800 kbit/s
// RULE11: power and brown-out reset state machine
// RULE12: bit is high then low, 1.25 us
// RULE13: bit value from high phase length
// RULE14: green, red, blue, msb first
// RULE15: sender holds low 300 us at end
// RULE16: frame end shows word, rearms capture
// RULE17: outputs hold old word during frame
module crp_pixel_rx import crp_pkg::*; #(
  parameter int GAP_CYCLES = GAP_CYC,
  parameter int SILENT_CYCLES = SILENT_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic supply_ok_in,
  input wire logic primary_serial_in,
  input wire logic backup_serial_in,
  output logic serial_out,
  output crp_colour_t colour_out,
  output logic pwm_green_out,
  output logic pwm_red_out,
  output logic pwm_blue_out,
  output logic on_backup_out,
  output logic stream_mismatch_out
);
  logic sup1_ff, sup2_ff;
  wire pwr_n = rst_n_in & sup2_ff;
  crp_rx_t p_rx, b_rx;

  // power-on and brown-out: supply dip resets everything incl. backup choice
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sup1_ff <= 1'b0;
      sup2_ff <= 1'b0;
    end else begin
      sup1_ff <= supply_ok_in;
      sup2_ff <= sup1_ff; // RULE11
    end
  end

  crp_bit_decoder #(.GAP_CYCLES(GAP_CYCLES), .SILENT_CYCLES(SILENT_CYCLES)) u_primary (
    .clk_in(clk_in), .rst_n_in(pwr_n), .line_in(primary_serial_in), .rx_out(p_rx));
  crp_bit_decoder #(.GAP_CYCLES(GAP_CYCLES), .SILENT_CYCLES(SILENT_CYCLES)) u_backup (
    .clk_in(clk_in), .rst_n_in(pwr_n), .line_in(backup_serial_in), .rx_out(b_rx));

  ////////////////////////////////////////////////////////////////////////////////
  // input selection and backup comparison
  logic on_backup_ff, mismatch_ff, b_pend_ff, b_bit_ff;
  logic [4:0] b_cnt_ff;
  wire b_skip_done = (b_cnt_ff == SKIP_BITS);
  wire b_rem_valid = b_rx.valid & b_skip_done; // RULE4
  wire switch_now = ~on_backup_ff & p_rx.silent & b_rem_valid; // RULE5
  wire use_backup = on_backup_ff | switch_now;
  wire sel_valid = use_backup ? b_rem_valid : p_rx.valid;
  wire sel_value = use_backup ? b_rx.value : p_rx.value;
  wire sel_gap = use_backup ? b_rx.gap : p_rx.gap;
  wire cmp_now = ~use_backup & p_rx.valid & b_pend_ff;

  always_ff @(posedge clk_in) begin
    if (!pwr_n) begin
      on_backup_ff <= 1'b0;
      mismatch_ff <= 1'b0;
      b_pend_ff <= 1'b0;
      b_bit_ff <= 1'b0;
      b_cnt_ff <= 5'h00;
    end else begin
      if (switch_now)
        on_backup_ff <= 1'b1; // RULE6
      if (b_rx.gap)
        b_cnt_ff <= 5'h00;
      else if (b_rx.valid & ~b_skip_done)
        b_cnt_ff <= b_cnt_ff + 5'h01; // RULE4
      if (b_rem_valid) begin
        b_pend_ff <= 1'b1;
        b_bit_ff <= b_rx.value;
      end else if (cmp_now | b_rx.gap) begin
        b_pend_ff <= 1'b0;
      end
      // a mismatch seen this cycle beats the clear at frame end
      if (cmp_now & (b_bit_ff != p_rx.value))
        mismatch_ff <= 1'b1; // RULE4
      else if (sel_gap)
        mismatch_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // capture of the own word
  crp_cap_state_t state_ff;
  logic [4:0] bit_cnt_ff;
  logic [WORD_BITS-1:0] shift_ff;
  crp_colour_t word_ff, colour_ff;
  logic word_ready_ff;
  wire cap_bit = sel_valid & (state_ff == CRP_CAPTURE);
  wire fwd_bit = sel_valid & (state_ff == CRP_FORWARD); // RULE2
  wire [WORD_BITS-1:0] shift_nxt = {shift_ff[WORD_BITS-2:0], sel_value}; // RULE14

  always_ff @(posedge clk_in) begin
    if (!pwr_n) begin
      state_ff <= CRP_CAPTURE; // RULE11
      bit_cnt_ff <= 5'h00;
      shift_ff <= '0;
      word_ff <= '0;
      word_ready_ff <= 1'b0;
      colour_ff <= '0;
    end else if (sel_gap) begin
      state_ff <= CRP_CAPTURE; // RULE16
      bit_cnt_ff <= 5'h00;
      word_ready_ff <= 1'b0;
      if (word_ready_ff)
        colour_ff <= word_ff; // RULE16
    end else if (cap_bit) begin
      shift_ff <= shift_nxt;
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
      if (bit_cnt_ff == LAST_BIT_IDX) begin
        word_ff <= crp_colour_t'(shift_nxt); // RULE1
        word_ready_ff <= 1'b1;
        state_ff <= CRP_FORWARD; // RULE3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // two-entry buffer between receiver and regenerator
  logic [1:0] buf_mem_ff;
  logic buf_wr_ff, buf_rd_ff;
  logic [1:0] buf_cnt_ff;
  crp_tx_state_t tx_state_ff;
  wire buf_ready = (buf_cnt_ff != 2'h2);
  wire buf_valid = (buf_cnt_ff != 2'h0);
  wire buf_push = fwd_bit & buf_ready;
  wire buf_pop = buf_valid & (tx_state_ff == CRP_TX_IDLE);

  always_ff @(posedge clk_in) begin
    if (!pwr_n) begin
      buf_mem_ff <= 2'h0;
      buf_wr_ff <= 1'b0;
      buf_rd_ff <= 1'b0;
      buf_cnt_ff <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_mem_ff[buf_wr_ff] <= sel_value;
        buf_wr_ff <= ~buf_wr_ff;
      end
      if (buf_pop)
        buf_rd_ff <= ~buf_rd_ff;
      buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // regenerator: clean high phase then low to a fixed bit period
  logic [6:0] tx_cnt_ff, tx_high_ff;
  logic serial_ff;

  always_ff @(posedge clk_in) begin
    if (!pwr_n) begin
      tx_state_ff <= CRP_TX_IDLE;
      tx_cnt_ff <= 7'h00;
      tx_high_ff <= TX_HIGH0_CYC;
      serial_ff <= 1'b0;
    end else begin
      case (tx_state_ff)
        CRP_TX_IDLE: begin
          if (buf_pop) begin
            tx_high_ff <= buf_mem_ff[buf_rd_ff] ? TX_HIGH1_CYC : TX_HIGH0_CYC; // RULE13
            tx_cnt_ff <= 7'h01;
            serial_ff <= 1'b1; // RULE2
            tx_state_ff <= CRP_TX_HIGH;
          end
        end
        CRP_TX_HIGH: begin
          tx_cnt_ff <= tx_cnt_ff + 7'h01;
          if (tx_cnt_ff == tx_high_ff) begin
            serial_ff <= 1'b0;
            tx_state_ff <= CRP_TX_LOW;
          end
        end
        CRP_TX_LOW: begin
          tx_cnt_ff <= tx_cnt_ff + 7'h01;
          // full period keeps the forwarded rate at the link limit
          // one cycle of the period is spent in idle, so stop one early
          if (tx_cnt_ff == BIT_CYC - 7'h01)
            tx_state_ff <= CRP_TX_IDLE; // RULE12 RULE10
        end
        default: tx_state_ff <= CRP_TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // 256-step duty per channel, one sweep per 2 kHz refresh period
  logic [7:0] pre_cnt_ff, pwm_cnt_ff;
  logic [2:0] pwm_ff;
  wire pwm_tick = (pre_cnt_ff == STEP_CYC - 8'h01);

  always_ff @(posedge clk_in) begin
    if (!pwr_n) begin
      pre_cnt_ff <= 8'h00;
      pwm_cnt_ff <= 8'h00;
      pwm_ff <= 3'h0;
    end else begin
      pre_cnt_ff <= pwm_tick ? 8'h00 : pre_cnt_ff + 8'h01; // RULE9
      if (pwm_tick)
        pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
      pwm_ff <= {colour_ff.green > pwm_cnt_ff, colour_ff.red > pwm_cnt_ff,
                 colour_ff.blue > pwm_cnt_ff}; // RULE8
    end
  end

  assign serial_out = serial_ff;
  assign colour_out = colour_ff;
  assign {pwm_green_out, pwm_red_out, pwm_blue_out} = pwm_ff;
  assign on_backup_out = on_backup_ff;
  assign stream_mismatch_out = mismatch_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  logic [7:0] chk_high_ff, chk_per_ff;
  always_ff @(posedge clk_in) begin
    if (!pwr_n) begin
      chk_high_ff <= 8'h00;
      chk_per_ff <= 8'hff;
    end else begin
      chk_high_ff <= serial_ff ? chk_high_ff + 8'h01 : 8'h00;
      chk_per_ff <= (serial_ff & ~$past(serial_ff)) ? 8'h01 :
                    (chk_per_ff == 8'hff ? chk_per_ff : chk_per_ff + 8'h01);
    end
  end

  a_backup_stays: assert property (@(posedge clk_in) disable iff (!pwr_n) // RULE6
    on_backup_ff |=> on_backup_ff)
    else $error("left the backup input without a power cycle");
  a_switch_cause: assert property (@(posedge clk_in) disable iff (!pwr_n) // RULE5
    $rose(on_backup_ff) |-> $past(p_rx.silent && b_rem_valid))
    else $error("switched to backup while primary was live");
  a_colour_hold: assert property (@(posedge clk_in) disable iff (!pwr_n) // RULE17
    !(sel_gap && word_ready_ff) |=> $stable(colour_ff))
    else $error("channel outputs changed inside a frame");
  a_latch_on_gap: assert property (@(posedge clk_in) disable iff (!pwr_n) // RULE16
    sel_gap && word_ready_ff |=> colour_ff == $past(word_ff) && state_ff == CRP_CAPTURE)
    else $error("frame end did not show the captured word");
  a_word_count: assert property (@(posedge clk_in) disable iff (!pwr_n) // RULE1
    $rose(word_ready_ff) |-> $past(bit_cnt_ff) == LAST_BIT_IDX && $past(cap_bit))
    else $error("word latched after the wrong bit count");
  a_no_own_fwd: assert property (@(posedge clk_in) disable iff (!pwr_n) // RULE3
    buf_push |-> state_ff == CRP_FORWARD && word_ready_ff)
    else $error("own colour bit was forwarded");
  a_high_width: assert property (@(posedge clk_in) disable iff (!pwr_n) // RULE13
    $fell(serial_ff) |-> chk_high_ff == {1'b0, TX_HIGH0_CYC} || chk_high_ff == {1'b0, TX_HIGH1_CYC})
    else $error("regenerated high phase has the wrong length");
  a_bit_period: assert property (@(posedge clk_in) disable iff (!pwr_n) // RULE12
    $rose(serial_ff) |-> chk_per_ff >= {1'b0, BIT_CYC})
    else $error("regenerated bit period too short");
  a_pwm_step: assert property (@(posedge clk_in) disable iff (!pwr_n) // RULE9
    !pwm_tick |=> $stable(pwm_cnt_ff))
    else $error("duty counter stepped off the refresh tick");
  a_brownout: assert property (@(posedge clk_in) disable iff (!rst_n_in) // RULE11
    !sup2_ff |=> state_ff == CRP_CAPTURE && !on_backup_ff && bit_cnt_ff == 5'h00)
    else $error("supply dip did not reset the receiver");
endmodule

`default_nettype wire

// ===== bench/crp_line_sender.sv
// upstream sender model driving one pulse-width coded data line
`timescale 1ns/1ps
`default_nettype none
module crp_line_sender (
  input wire logic clk_in,
  output logic line_out
);
  // line idles low between frames, as the link requires
  initial line_out = 1'b0;
  task automatic send_bits(input logic [63:0] bits, input int n);
    int h;
    for (int i = n - 1; i >= 0; i--) begin
      h = bits[i] ? 85 : 40;
      @(posedge clk_in);
      #1 line_out = 1'b1;
      repeat (h) @(posedge clk_in);
      #1 line_out = 1'b0;
      repeat (124 - h) @(posedge clk_in);
    end
  endtask
  task automatic pulse(input int hi, input int lo);
    @(posedge clk_in);
    #1 line_out = 1'b1;
    repeat (hi) @(posedge clk_in);
    #1 line_out = 1'b0;
    repeat (lo) @(posedge clk_in);
  endtask
  // hold low well past the scaled gap, the safe margin
  task automatic end_frame();
    repeat (400) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the cascaded rgb pixel receiver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import crp_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic supply_ok_in = 1'b1;
  logic prim_line;
  logic bk_line;
  logic serial_out;
  crp_colour_t colour_out;
  logic pwm_g, pwm_r, pwm_b, on_backup_out, stream_mismatch_out;
  int failures = 0;
  int n_tests = 0;
  int hi_cnt = 0;
  int widths[$];
  always #5 clk_in = ~clk_in;
  crp_line_sender pr_u (.clk_in(clk_in), .line_out(prim_line));
  crp_line_sender bk_u (.clk_in(clk_in), .line_out(bk_line));
  // short gap and silence counts keep the run brief
  crp_pixel_rx #(.GAP_CYCLES(300), .SILENT_CYCLES(200)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .supply_ok_in(supply_ok_in),
    .primary_serial_in(prim_line), .backup_serial_in(bk_line),
    .serial_out(serial_out), .colour_out(colour_out),
    .pwm_green_out(pwm_g), .pwm_red_out(pwm_r), .pwm_blue_out(pwm_b),
    .on_backup_out(on_backup_out), .stream_mismatch_out(stream_mismatch_out));
  // high width of each forwarded bit, for decoding later
  always @(posedge clk_in) begin
    if (serial_out === 1'b1) hi_cnt <= hi_cnt + 1;
    else if (hi_cnt != 0) begin
      widths.push_back(hi_cnt);
      hi_cnt <= 0;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_fwd(input logic [3:0] exp, input int n);
    chk(32'(widths.size()), 32'(n));
    for (int i = 0; i < widths.size() && i < n; i++) begin
      chk(32'(widths[i]), exp[n-1-i] ? 32'h55 : 32'h28);
    end
    widths.delete();
  endtask
  task automatic frame(input logic [63:0] bits, input int n, input crp_colour_t old);
    pr_u.send_bits(bits, n);
    chk(32'(colour_out), 32'(old));
    pr_u.end_frame();
  endtask
  task automatic t_basic();
    frame({24'h12_3456, 4'ha}, 28, 24'h0);
    chk(32'(colour_out), 32'h0012_3456);
    chk_fwd(4'ha, 4);
    $display("test basic done");
  endtask
  task automatic t_pause();
    pr_u.send_bits(64'h0000_0c3a, 12);
    // a runt pulse, then a pause shorter than silence and gap
    pr_u.pulse(20, 150);
    frame(64'h0000_050f, 12, 24'h12_3456);
    chk(32'(colour_out), 32'h00c3_a50f);
    chk_fwd(4'h0, 0);
    $display("test pause done");
  endtask
  task automatic t_short();
    frame(64'h0000_03ff, 10, 24'hc3_a50f);
    chk(32'(colour_out), 32'h00c3_a50f);
    chk_fwd(4'h0, 0);
    $display("test short done");
  endtask
  task automatic t_compare(input logic [3:0] ptail, input logic flag);
    fork
      bk_u.send_bits({24'hff_ffff, 24'h5a_00ff, 4'h5}, 52);
      begin
        repeat (3005) @(posedge clk_in);
        pr_u.send_bits({24'h5a_00ff, ptail}, 28);
      end
    join
    repeat (100) @(posedge clk_in);
    chk(32'(stream_mismatch_out), 32'(flag));
    chk(32'(on_backup_out), 32'h0);
    pr_u.end_frame();
    chk(32'(stream_mismatch_out), 32'h0);
    chk(32'(colour_out), 32'h005a_00ff);
    chk_fwd(ptail, 4);
    $display("test compare done");
  endtask
  task automatic t_pwm();
    int g, r, b;
    g = 0;
    r = 0;
    b = 0;
    repeat (256 * STEP_CYC) begin
      @(posedge clk_in);
      g += (pwm_g === 1'b1);
      r += (pwm_r === 1'b1);
      b += (pwm_b === 1'b1);
    end
    chk(32'(g), 32'(90 * STEP_CYC));
    chk(32'(r), 32'h0);
    chk(32'(b), 32'(255 * STEP_CYC));
    $display("test pwm done");
  endtask
  task automatic t_switch();
    bk_u.send_bits({24'h0f_0f0f, 24'h33_cc81, 4'h9}, 52);
    bk_u.end_frame();
    chk(32'(on_backup_out), 32'h1);
    chk(32'(colour_out), 32'h0033_cc81);
    chk_fwd(4'h9, 4);
    frame(64'h0077_1188, 24, 24'h33_cc81);
    chk(32'(colour_out), 32'h0033_cc81);
    chk(32'(on_backup_out), 32'h1);
    @(posedge clk_in);
    #1 supply_ok_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1 supply_ok_in = 1'b1;
    repeat (6) @(posedge clk_in);
    chk(32'(on_backup_out), 32'h0);
    chk(32'(colour_out), 32'h0);
    frame(64'h0077_1188, 24, 24'h0);
    chk(32'(colour_out), 32'h0077_1188);
    chk_fwd(4'h0, 0);
    $display("test switch done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #990000;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    repeat (4) @(posedge clk_in);
    chk(32'(colour_out), 32'h0);
    chk(32'(serial_out), 32'h0);
    t_basic();
    t_pause();
    t_short();
    t_compare(4'h5, 1'b0);
    t_compare(4'h7, 1'b1);
    t_pwm();
    t_switch();
    end_of_test();
  end
endmodule
`default_nettype wire
